/* rtl/dfm_monitor.sv */
// Drive fault monitor: power-up supervision, fault coding, lamps and APB access.
//
// Overview of operation
// - Fault class on two tags, three bits, lamps
// - Sequence fault: tag1 low, tag0 blinks, state
// - No solenoid current in state 2: lock check
// - Speed below 94 percent after 50 s
// - First acceleration unfinished after 16 s
// - Initial seek unfinished after 4 s
// - Overheat or sensor fault when ready: emergency
// - Illegal command when busy: device check 1
// - Bad write sequence: device check 2
// - Off track while writing: off-track check
// - Write driver failure: write unsafe check
// - Write while protected: write protect check
// - Several heads selected while writing: multiple head
// - Seek tag set; return-to-zero over 4 s
// - Seek over 67 ms: seek timeout
// - Overshoot to wrong cylinder: overshoot check
// - Guard band during seek: seek guard check
// - Guard band while following: linear guard check
// - Outer guard during return-to-zero: outer check
// - Cylinder above 822 raises illegal cylinder
// - Drop power good when supply is low
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "dfm_regs.svh"

module dfm_monitor #(
  parameter longint CLK_HZ = `DFM_CLK_HZ,
  parameter longint ACCEL_CYC = `DFM_ACCEL_S * `DFM_CLK_HZ,
  parameter longint ACMP_CYC = `DFM_ACMP_S * `DFM_CLK_HZ,
  parameter longint ISEEK_CYC = `DFM_ISEEK_S * `DFM_CLK_HZ,
  parameter longint RTZ_CYC = `DFM_RTZ_S * `DFM_CLK_HZ,
  parameter longint SEEK_CYC = (`DFM_SEEK_MS * `DFM_CLK_HZ) / 1000,
  parameter longint BLINK_CYC = `DFM_BLINK_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Drive sense pins (asynchronous)
  input wire dfm_pkg::dfm_sense_t sense_i,
  input wire logic protect_switch_i,
  // Status toward the control unit
  output dfm_pkg::dfm_code_t fault_o,
  output logic [4:0] fault_lamp_o,
  output logic device_check_flag_o,
  output logic seek_error_flag_o,
  output logic power_good_flag_o,
  output logic ready_o
);
  import dfm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  dfm_sense_t sense_m; // First stage, read only by the second
  dfm_sense_t sn; // Synchronised sense
  logic prot_m;
  logic prot_s;

  // Two-flop sync of every pin
  always_ff @(posedge core_clk_i)
  begin
    sense_m <= sense_i;
    sn <= sense_m;
    prot_m <= protect_switch_i;
    prot_s <= prot_m;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic clear_req; // One-cycle software clear
  logic sw_protect; // Software protect from the control register
  logic [9:0] cylinder_address_value; // Loaded cylinder
  logic cyl_load; // Cylinder written this cycle
  dfm_code_t code_q; // Held fault code
  logic fault_valid; // A fault is latched
  dfm_seq_t seq; // Sequence state
  logic apb_acc;

  assign apb_acc = psel_i & penable_i;
  // Zero wait states, so the slave is always ready
  assign pready_o = 1'b1;

  // Unmapped address answered with error
  always_comb
  begin
    pslverr_o = 1'b0;
    if (apb_acc && !(paddr_i == `DFM_CTRL_ADDR || paddr_i == `DFM_STATUS_ADDR
        || paddr_i == `DFM_CODE_ADDR || paddr_i == `DFM_CYL_ADDR))
      pslverr_o = 1'b1;
  end

  // Control writes
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      clear_req <= 1'b0;
      sw_protect <= 1'b0;
      cylinder_address_value <= 10'h000;
      cyl_load <= 1'b0;
    end
    else
    begin
      clear_req <= 1'b0;
      cyl_load <= 1'b0;
      if (apb_acc && pwrite_i && paddr_i == `DFM_CTRL_ADDR)
      begin
        clear_req <= pwdata_i[`DFM_CTRL_CLEAR_BIT];
        sw_protect <= pwdata_i[`DFM_CTRL_PROTECT_BIT];
      end
      if (apb_acc && pwrite_i && paddr_i == `DFM_CYL_ADDR)
      begin
        cylinder_address_value <= pwdata_i[9:0];
        cyl_load <= 1'b1;
      end
    end
  end

  // Read data registered in the setup phase
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      unique case (paddr_i)
        `DFM_CTRL_ADDR: prdata_o <= {30'h0, sw_protect, 1'b0};
        `DFM_STATUS_ADDR: prdata_o <= {27'h0, ready_o, fault_valid && code_q.tag == `DFM_TAG_SEQ,
                                      seek_error_flag_o, device_check_flag_o, power_good_flag_o};
        `DFM_CODE_ADDR: prdata_o <= {26'h0, fault_valid, code_q};
        `DFM_CYL_ADDR: prdata_o <= {22'h0, cylinder_address_value};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequence and its timer
  logic [39:0] seq_cnt; // Cycles in current state
  logic seq_fail;
  logic [2:0] seq_code;

  always_comb
  begin
    seq_fail = 1'b0;
    seq_code = 3'h0;
    unique case (seq)
      DFM_ST_SPIN:
      begin
        if (!sn.solenoid_current)
        begin
          seq_fail = 1'b1;
          seq_code = `DFM_SEQ_LOCK;
        end
        else if (!sn.speed_ok && seq_cnt >= 40'(ACCEL_CYC))
        begin
          seq_fail = 1'b1;
          seq_code = `DFM_SEQ_ACCEL;
        end
      end
      DFM_ST_ACMP:
        if (!sn.accel_done && seq_cnt >= 40'(ACMP_CYC))
        begin
          seq_fail = 1'b1;
          seq_code = `DFM_SEQ_ACMP;
        end
      DFM_ST_ISEEK:
        if (!sn.iseek_done && seq_cnt >= 40'(ISEEK_CYC))
        begin
          seq_fail = 1'b1;
          seq_code = `DFM_SEQ_ISEEK;
        end
      DFM_ST_READY:
        if (sn.overheat || sn.spindle_fault)
        begin
          seq_fail = 1'b1;
          seq_code = `DFM_SEQ_EMERG;
        end
      default: ;
    endcase
  end

  // Sequence steps; any failure falls back to idle (not ready)
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      seq <= DFM_ST_IDLE;
      seq_cnt <= 40'h0;
    end
    else if (!sn.dc_ok || seq_fail || fault_valid)
    begin
      seq <= DFM_ST_IDLE;
      seq_cnt <= 40'h0;
    end
    else
    begin
      seq_cnt <= seq_cnt + 40'h1;
      unique case (seq)
        DFM_ST_IDLE:
        begin
          seq <= DFM_ST_SPIN;
          seq_cnt <= 40'h0;
        end
        DFM_ST_SPIN:
          if (sn.speed_ok)
          begin
            seq <= DFM_ST_ACMP;
            seq_cnt <= 40'h0;
          end
        DFM_ST_ACMP:
          if (sn.accel_done)
          begin
            seq <= DFM_ST_ISEEK;
            seq_cnt <= 40'h0;
          end
        DFM_ST_ISEEK:
          if (sn.iseek_done)
          begin
            seq <= DFM_ST_READY;
            seq_cnt <= 40'h0;
          end
        DFM_ST_READY: ;
        default: seq <= DFM_ST_IDLE;
      endcase
    end
  end

  assign ready_o = (seq == DFM_ST_READY);
  // Supply sensing drives the power good line directly
  assign power_good_flag_o = sn.dc_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Seek and return-to-zero timers
  logic [39:0] seek_cnt;
  logic [39:0] rtz_cnt;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      seek_cnt <= 40'h0;
      rtz_cnt <= 40'h0;
    end
    else
    begin
      seek_cnt <= sn.seeking ? seek_cnt + 40'h1 : 40'h0;
      rtz_cnt <= sn.rtz_active ? rtz_cnt + 40'h1 : 40'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device check and seek error detection, priority top down
  logic dv_fail;
  logic [2:0] dv_code;
  logic sk_fail;
  logic [2:0] sk_code;
  logic protected_now;

  assign protected_now = prot_s | sw_protect;

  always_comb
  begin
    dv_fail = 1'b1;
    dv_code = 3'h0;
    if (seq == DFM_ST_READY && (sn.overheat || sn.spindle_fault))
      dv_code = `DFM_DV_EMERG;
    else if (sn.illegal_cmd && (!ready_o || sn.seeking || sn.rtz_active
             || seek_error_flag_o))
      dv_code = `DFM_DV_CTRL1;
    else if (sn.write_seq_err)
      dv_code = `DFM_DV_CTRL2;
    else if (sn.write_active && sn.off_track)
      dv_code = `DFM_DV_OFFTRK;
    else if (sn.write_active && sn.write_fail)
      dv_code = `DFM_DV_UNSAFE;
    else if (sn.write_active && protected_now)
      dv_code = `DFM_DV_PROT;
    else if (sn.write_active && sn.multi_head)
      dv_code = `DFM_DV_MHEAD;
    else
      dv_fail = 1'b0;
  end

  always_comb
  begin
    sk_fail = 1'b1;
    sk_code = 3'h0;
    if (cylinder_address_value > `DFM_MAX_CYL)
      sk_code = `DFM_SK_CYL;
    else if (sn.rtz_active && rtz_cnt >= 40'(RTZ_CYC))
      sk_code = `DFM_SK_RTZ;
    else if (sn.seeking && seek_cnt >= 40'(SEEK_CYC))
      sk_code = `DFM_SK_TMO;
    else if (sn.seek_done && sn.overshoot)
      sk_code = `DFM_SK_OVR;
    else if (sn.rtz_active && sn.outer_guard)
      sk_code = `DFM_SK_OGB;
    else if (sn.seeking && sn.guard_band)
      sk_code = `DFM_SK_SGB;
    else if (sn.track_follow && sn.guard_band)
      sk_code = `DFM_SK_LGB;
    else
      sk_fail = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch: first fault held; a new fault beats a clear
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      fault_valid <= 1'b0;
      code_q <= '0;
    end
    else if (!fault_valid && (seq_fail || dv_fail || sk_fail))
    begin
      fault_valid <= 1'b1;
      if (dv_fail && dv_code == `DFM_DV_EMERG)
        code_q <= '{tag: `DFM_TAG_SEQ, bits: `DFM_SEQ_EMERG};
      else if (seq_fail)
        code_q <= '{tag: `DFM_TAG_SEQ, bits: seq_code};
      else if (dv_fail)
        code_q <= '{tag: `DFM_TAG_DEVICE_CHECK_FLAG, bits: dv_code};
      else
        code_q <= '{tag: `DFM_TAG_SEEK, bits: sk_code};
    end
    else if (clear_req && !(seq_fail || dv_fail || sk_fail))
    begin
      fault_valid <= 1'b0;
      code_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blink of the lower tag for sequence faults
  logic [31:0] blink_cnt;
  logic blink;

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      blink_cnt <= 32'h0;
      blink <= 1'b0;
    end
    else if (blink_cnt >= 32'(BLINK_CYC - 1))
    begin
      blink_cnt <= 32'h0;
      blink <= ~blink;
    end
    else
      blink_cnt <= blink_cnt + 32'h1;
  end

  // Outputs registered; lamps mirror status lines
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      fault_o <= '0;
      fault_lamp_o <= 5'h00;
      device_check_flag_o <= 1'b0;
      seek_error_flag_o <= 1'b0;
    end
    else
    begin
      fault_o <= code_q;
      fault_lamp_o <= code_q;
      if (fault_valid && code_q.tag == `DFM_TAG_SEQ)
      begin
        fault_o.tag <= {1'b0, blink};
        fault_lamp_o[4:3] <= {1'b0, blink};
      end
      device_check_flag_o <= fault_valid && code_q.tag == `DFM_TAG_DEVICE_CHECK_FLAG;
      seek_error_flag_o <= fault_valid && code_q.tag == `DFM_TAG_SEEK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_cyl;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (cylinder_address_value > `DFM_MAX_CYL && !fault_valid) |=> fault_valid;
  endproperty
  a_cyl: assert property (p_cyl) else $error("illegal cylinder not latched");

  property p_hold;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (fault_valid && !clear_req) |=> (fault_valid && $stable(code_q));
  endproperty
  a_hold: assert property (p_hold) else $error("fault code changed");

  property p_seq_tag;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (fault_valid && code_q.tag == `DFM_TAG_SEQ) ##1 fault_valid |-> !fault_o.tag[1];
  endproperty
  a_seq_tag: assert property (p_seq_tag) else $error("upper tag high");

  property p_lock;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (seq == DFM_ST_SPIN && !sn.solenoid_current && !fault_valid)
      |=> code_q.bits == `DFM_SEQ_LOCK;
  endproperty
  a_lock: assert property (p_lock) else $error("lock check missed");

  property p_pwr;
    @(posedge core_clk_i) disable iff (!resetn_i)
    !sn.dc_ok |-> !power_good_flag_o ##1 (seq == DFM_ST_IDLE);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power good wrong");

  property p_dv;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (fault_valid && code_q.tag == `DFM_TAG_DEVICE_CHECK_FLAG) |=> device_check_flag_o;
  endproperty
  a_dv: assert property (p_dv) else $error("device check not flagged");

  property p_sk;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (fault_valid && code_q.tag == `DFM_TAG_SEEK) |=> fault_o.tag == `DFM_TAG_SEEK;
  endproperty
  a_sk: assert property (p_sk) else $error("seek tag wrong");

  property p_prot;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (!fault_valid && sn.write_active && protected_now && !sn.off_track
     && !sn.write_fail && !sn.illegal_cmd && !sn.write_seq_err && !seq_fail)
      |=> code_q.bits == `DFM_DV_PROT;
  endproperty
  a_prot: assert property (p_prot) else $error("protect check missed");

  property p_ready_emerg;
    @(posedge core_clk_i) disable iff (!resetn_i)
    (ready_o && sn.overheat) |=> !ready_o;
  endproperty
  a_ready_emerg: assert property (p_ready_emerg) else $error("still ready");

  c_ready: cover property (@(posedge core_clk_i) disable iff (!resetn_i) ready_o);
  c_seq: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
    fault_valid && code_q.tag == `DFM_TAG_SEQ);
  c_dv: cover property (@(posedge core_clk_i) disable iff (!resetn_i) device_check_flag_o);
  c_sk: cover property (@(posedge core_clk_i) disable iff (!resetn_i) seek_error_flag_o);

endmodule : dfm_monitor

/* rtl/dfm_regs.svh */
// Constants of the drive fault monitor: register map, fields, codes and timing.
`ifndef DFM_REGS_SVH
`define DFM_REGS_SVH

// Register byte addresses
`define DFM_CTRL_ADDR 12'h000
`define DFM_STATUS_ADDR 12'h004
`define DFM_CODE_ADDR 12'h008
`define DFM_CYL_ADDR 12'h00c
// Control fields
`define DFM_CTRL_CLEAR_BIT 0
`define DFM_CTRL_PROTECT_BIT 1
`define DFM_CTRL_RESET 32'h0000_0000
// Status fields
`define DFM_STAT_PWR_BIT 0
`define DFM_STAT_DEVICE_CHECK_FLAG_BIT 1
`define DFM_STAT_SEEK_ERROR_FLAG_BIT 2
`define DFM_STAT_SEQ_BIT 3
`define DFM_STAT_READY_BIT 4
// Largest legal cylinder
`define DFM_MAX_CYL 10'd822
// Fault class tags {tag1,tag0}
`define DFM_TAG_SEQ 2'h0
`define DFM_TAG_DEVICE_CHECK_FLAG 2'h1
`define DFM_TAG_SEEK 2'h2
// Sequence codes
`define DFM_SEQ_LOCK 3'h3
`define DFM_SEQ_ACCEL 3'h2
`define DFM_SEQ_ACMP 3'h6
`define DFM_SEQ_ISEEK 3'h7
`define DFM_SEQ_EMERG 3'h5
// Device check codes
`define DFM_DV_CTRL1 3'h1
`define DFM_DV_CTRL2 3'h2
`define DFM_DV_OFFTRK 3'h3
`define DFM_DV_UNSAFE 3'h4
`define DFM_DV_PROT 3'h5
`define DFM_DV_MHEAD 3'h6
`define DFM_DV_EMERG 3'h7
// Seek error codes
`define DFM_SK_RTZ 3'h1
`define DFM_SK_TMO 3'h2
`define DFM_SK_OVR 3'h3
`define DFM_SK_SGB 3'h4
`define DFM_SK_LGB 3'h5
`define DFM_SK_OGB 3'h6
`define DFM_SK_CYL 3'h7
// Timing in native units
`define DFM_ACCEL_S 50
`define DFM_ACMP_S 16
`define DFM_ISEEK_S 4
`define DFM_RTZ_S 4
`define DFM_SEEK_MS 67
`define DFM_CLK_HZ 125000000
// Lamp blink half period of the lower tag (cycles)
`define DFM_BLINK_CYC 62500000

`endif

/* rtl/dfm_pkg.sv */
// Types of the drive fault monitor.
package dfm_pkg;

  // Power-up sequence states, numbered as the drive numbers them
  typedef enum logic [2:0] {
    DFM_ST_IDLE = 3'b000,
    DFM_ST_SPIN = 3'b010,
    DFM_ST_READY = 3'b100,
    DFM_ST_ACMP = 3'b110,
    DFM_ST_ISEEK = 3'b111
  } dfm_seq_t;

  // Encoded fault presented on the status lines
  typedef struct packed {
    logic [1:0] tag;
    logic [2:0] bits;
  } dfm_code_t;

  // Drive sense inputs
  typedef struct packed {
    logic solenoid_current;
    logic speed_ok;
    logic accel_done;
    logic iseek_done;
    logic overheat;
    logic spindle_fault;
    logic illegal_cmd;
    logic write_seq_err;
    logic write_active;
    logic off_track;
    logic write_fail;
    logic multi_head;
    logic seeking;
    logic seek_done;
    logic overshoot;
    logic guard_band;
    logic outer_guard;
    logic track_follow;
    logic rtz_active;
    logic dc_ok;
  } dfm_sense_t;

endpackage : dfm_pkg

/* bench/dfm_drive_model.sv */
// Drive-side model: sense levels that the monitor supervises.
`timescale 1ns/1ps
module dfm_drive_model
  import dfm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Scenario control
  input wire logic [2:0] stuck_i,
  input wire logic dc_drop_i,
  input wire dfm_pkg::dfm_sense_t extra_i,
  // Sense levels toward the monitor
  output dfm_pkg::dfm_sense_t sense_o
);
  ////////////////////////////////////////////////////////////////////////
  logic [4:0] up_cnt; // Cycles since power-up release

  // Saturating progress counter, so stages settle at fixed times
  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      up_cnt <= 5'h00;
    else if (up_cnt != 5'h1f)
      up_cnt <= up_cnt + 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // One stage may be held back to provoke its check
  always_comb
  begin
    sense_o = extra_i;
    sense_o.solenoid_current = (stuck_i != 3'h1);
    sense_o.speed_ok = (up_cnt >= 5'h06) && (stuck_i != 3'h2);
    sense_o.accel_done = (up_cnt >= 5'h09) && (stuck_i != 3'h3);
    sense_o.iseek_done = (up_cnt >= 5'h0c) && (stuck_i != 3'h4);
    sense_o.dc_ok = !dc_drop_i;
  end
endmodule : dfm_drive_model

/* bench/tb.sv */
// Self-checking bench of the drive fault monitor.
`timescale 1ns/1ps
`include "dfm_regs.svh"
`define CHK(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
    end \
  end
module tb;
  import dfm_pkg::*;
  localparam int BLINK = 4; // Short blink half period
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic protect_switch_i = 1'b0;
  dfm_sense_t sense_i;
  dfm_code_t fault_o;
  logic [4:0] fault_lamp_o;
  logic device_check_flag_o;
  logic seek_error_flag_o;
  logic power_good_flag_o;
  logic ready_o;
  logic [2:0] stuck = 3'h0; // Stage the drive holds back
  logic dc_drop = 1'b0;
  dfm_sense_t extra = '0; // Fault conditions injected
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic err;
  logic [2:0] seqc [5] = '{3'h0, `DFM_SEQ_LOCK, `DFM_SEQ_ACCEL, `DFM_SEQ_ACMP, `DFM_SEQ_ISEEK};
  int slo [5] = '{0, 0, 48, 14, 6}; // Earliest cycle each stall may fire
  logic [4:0] ecode [15] = '{{`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_CTRL1}, {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_CTRL2},
    {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_OFFTRK}, {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_UNSAFE},
    {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_PROT}, {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_PROT},
    {`DFM_TAG_DEVICE_CHECK_FLAG, `DFM_DV_MHEAD}, {`DFM_TAG_SEEK, `DFM_SK_RTZ},
    {`DFM_TAG_SEEK, `DFM_SK_TMO}, {`DFM_TAG_SEEK, `DFM_SK_OVR},
    {`DFM_TAG_SEEK, `DFM_SK_SGB}, {`DFM_TAG_SEEK, `DFM_SK_LGB},
    {`DFM_TAG_SEEK, `DFM_SK_OGB}, {`DFM_TAG_SEQ, `DFM_SEQ_EMERG}, {`DFM_TAG_SEQ, `DFM_SEQ_EMERG}};

  ////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Short counts keep every timeout within a few hundred cycles
  dfm_monitor #(.ACCEL_CYC(50), .ACMP_CYC(16), .ISEEK_CYC(8), .RTZ_CYC(8), .SEEK_CYC(20),
    .BLINK_CYC(BLINK)) uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sense_i(sense_i),
    .protect_switch_i(protect_switch_i), .fault_o(fault_o), .fault_lamp_o(fault_lamp_o),
    .device_check_flag_o(device_check_flag_o), .seek_error_flag_o(seek_error_flag_o),
    .power_good_flag_o(power_good_flag_o), .ready_o(ready_o));

  dfm_drive_model drv (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .stuck_i(stuck),
    .dc_drop_i(dc_drop), .extra_i(extra), .sense_o(sense_i));

  ////////////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge core_clk_i);
    end
    if (n == 16)
      error_cnt++;
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : apb

  // Reset for 8 cycles with stage s stalled, or none when s is 0
  task automatic rst(input logic [2:0] s);
    stuck <= s;
    resetn_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    resetn_i <= 1'b1;
  endtask : rst

  // Bounded wait for any fault code; n returns the cycles taken
  task automatic wait_fault(output int n);
    n = 0;
    while (fault_o.bits === 3'h0 && n < 300)
    begin
      n++;
      @(posedge core_clk_i);
    end
    if (n == 300)
      error_cnt++;
    @(posedge core_clk_i);
  endtask : wait_fault

  task automatic wait_ready;
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge core_clk_i);
    end
    `CHK("ready", 1'b1, ready_o)
  endtask : wait_ready

  // Code on lines, lamps, flags and code register
  task automatic chk_fault(input logic [1:0] tg, input logic [2:0] bt);
    `CHK("fault bits", bt, fault_o.bits)
    `CHK("fault tag1", tg[1], fault_o.tag[1])
    `CHK("lamp", {tg[1], bt}, {fault_lamp_o[4], fault_lamp_o[2:0]})
    apb(1'b0, `DFM_CODE_ADDR, 32'h0);
    `CHK("code reg", {1'b1, tg[1], bt}, {rd[5:4], rd[2:0]})
    if (tg != `DFM_TAG_SEQ)
    begin
      `CHK("fault tag0", tg[0], fault_o.tag[0])
      `CHK("lamp tag0", tg[0], fault_lamp_o[3])
      `CHK("device flag", tg == `DFM_TAG_DEVICE_CHECK_FLAG, device_check_flag_o)
      `CHK("seek flag", tg == `DFM_TAG_SEEK, seek_error_flag_o)
    end
  endtask : chk_fault

  // Lower tag of a sequence fault toggles every BLINK cycles
  task automatic blink;
    logic prev;
    int k;
    k = 0;
    prev = fault_o.tag[0];
    repeat (8)
    begin
      @(posedge core_clk_i);
      if (fault_o.tag[0] !== prev)
        k++;
      prev = fault_o.tag[0];
    end
    `CHK("blink toggles", 8 / BLINK, k)
  endtask : blink

  // Remove the cause; code must stand until the clear write
  task automatic clr;
    logic [2:0] held;
    held = fault_o.bits;
    extra <= '0;
    protect_switch_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    `CHK("held code", held, fault_o.bits)
    apb(1'b1, `DFM_CTRL_ADDR, 32'h1 << `DFM_CTRL_CLEAR_BIT);
    repeat (3) @(posedge core_clk_i);
    `CHK("cleared", 3'h0, fault_o.bits)
  endtask : clr

  function automatic dfm_sense_t mk(input int i);
    case (i)
      0: return '{illegal_cmd: 1'b1, seeking: 1'b1, default: 1'b0};
      1: return '{write_seq_err: 1'b1, default: 1'b0};
      2: return '{write_active: 1'b1, off_track: 1'b1, default: 1'b0};
      3: return '{write_active: 1'b1, write_fail: 1'b1, default: 1'b0};
      6: return '{write_active: 1'b1, multi_head: 1'b1, default: 1'b0};
      7: return '{rtz_active: 1'b1, default: 1'b0};
      8: return '{seeking: 1'b1, default: 1'b0};
      9: return '{seek_done: 1'b1, overshoot: 1'b1, default: 1'b0};
      10: return '{seeking: 1'b1, guard_band: 1'b1, default: 1'b0};
      11: return '{track_follow: 1'b1, guard_band: 1'b1, default: 1'b0};
      12: return '{rtz_active: 1'b1, outer_guard: 1'b1, default: 1'b0};
      13: return '{overheat: 1'b1, default: 1'b0};
      14: return '{spindle_fault: 1'b1, default: 1'b0};
      default: return '{write_active: 1'b1, default: 1'b0};
    endcase
  endfunction : mk

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected several hundred cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    error_cnt++;
    $display("watchdog expired");
    stop_test();
  end

  initial
  begin
    int n;
    int lo;
    // Each power-up stage stalled in turn
    for (int i = 1; i <= 4; i++)
    begin
      rst(i[2:0]);
      wait_fault(n);
      chk_fault(`DFM_TAG_SEQ, seqc[i]);
      `CHK("stall time", 1'b1, n >= slo[i] && n <= slo[i] + 20)
      `CHK("not ready", 1'b0, ready_o)
      blink();
    end
    $display("test power-up faults done");
    dc_drop <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    `CHK("power good", 1'b0, power_good_flag_o)
    dc_drop <= 1'b0;
    rst(3'h0);
    wait_ready();
    apb(1'b0, `DFM_STATUS_ADDR, 32'h0);
    `CHK("status", 32'h1 << `DFM_STAT_PWR_BIT | 32'h1 << `DFM_STAT_READY_BIT, rd)
    // Illegal command while ready and still, and unprotected write, raise nothing
    extra <= '{illegal_cmd: 1'b1, write_active: 1'b1, default: 1'b0};
    repeat (20) @(posedge core_clk_i);
    `CHK("no fault", 5'h00, fault_o)
    extra <= '0;
    // Let the idle level settle before the next stimulus drives it
    @(posedge core_clk_i);
    $display("test ready done");
    // Device check and seek error codes, each cleared afterwards
    for (int i = 0; i < 13; i++)
    begin
      wait_ready();
      if (i == 5)
        apb(1'b1, `DFM_CTRL_ADDR, 32'h1 << `DFM_CTRL_PROTECT_BIT);
      protect_switch_i <= (i == 4);
      extra <= mk(i);
      wait_fault(n);
      chk_fault(ecode[i][4:3], ecode[i][2:0]);
      // Timer codes need their full count; all others appear within the sync latency
      lo = (i == 7) ? 8 : (i == 8) ? 20 : 0;
      `CHK("timeout", 1'b1, n >= lo && n <= lo + 8)
      clr();
    end
    $display("test fault codes done");
    wait_ready();
    apb(1'b1, `DFM_CYL_ADDR, 32'(`DFM_MAX_CYL) + 32'h1);
    wait_fault(n);
    chk_fault(`DFM_TAG_SEEK, `DFM_SK_CYL);
    apb(1'b1, `DFM_CTRL_ADDR, 32'h1 << `DFM_CTRL_CLEAR_BIT);
    repeat (3) @(posedge core_clk_i);
    `CHK("clear refused", `DFM_SK_CYL, fault_o.bits)
    apb(1'b1, `DFM_CYL_ADDR, 32'(`DFM_MAX_CYL));
    apb(1'b0, `DFM_CYL_ADDR, 32'h0);
    `CHK("cylinder", 32'(`DFM_MAX_CYL), rd)
    clr();
    apb(1'b1, 12'h010, 32'h5);
    `CHK("slverr", 1'b1, err)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    $display("test cylinder and map done");
    // Overheat and sensor fault while ready
    for (int i = 13; i < 15; i++)
    begin
      rst(3'h0);
      wait_ready();
      extra <= mk(i);
      wait_fault(n);
      chk_fault(ecode[i][4:3], ecode[i][2:0]);
      `CHK("ready dropped", 1'b0, ready_o)
      extra <= '0;
    end
    $display("test emergency done");
    stop_test();
  end
endmodule : tb
